// File: shared/mcc_pkg.sv
// Constants, register map and carrier types of the motion control core.
// Assumes a single 25 MHz clock domain and 32-bit Avalon-MM register access.
package mcc_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_SAMP = 8'h0C;
    localparam logic [7:0] OFS_FILT = 8'h10;
    localparam logic [7:0] OFS_CMD = 8'h14;
    localparam logic [7:0] OFS_PROF = 8'h18;
    localparam logic [7:0] OFS_POS = 8'h1C;
    localparam logic [7:0] OFS_COMM = 8'h20;
    localparam logic [7:0] OFS_PAT = 8'h24;
    localparam logic [7:0] OFS_MOTOR = 8'h28;

    // ------------------------------------------------------------------
    // Field positions and values after reset
    // ------------------------------------------------------------------
    localparam int unsigned ST_LIMIT = 0;
    localparam int unsigned ST_STOP = 1;
    localparam int unsigned ST_TICK = 2;
    localparam int unsigned ST_DONE = 3;
    localparam int unsigned ST_W = 4;
    localparam int unsigned FILT_SHIFT = 4;
    localparam logic [15:0] RST_SAMP = 16'h0064;
    localparam logic [15:0] RST_FILT = 16'h0010;
    localparam logic [23:0] RST_PROF = 24'h010001;
    localparam logic [23:0] RST_COMM = 24'h000010;
    localparam logic [15:0] RST_PAT = 16'h8421;

    // ------------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------------
    localparam logic [6:0] PWM_CNT = 7'h64;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MD_POS = 2'b00,
        MD_PVEL = 2'b01,
        MD_TRAP = 2'b11,
        MD_IVEL = 2'b10
    } mcc_mode_t;

    typedef struct packed {
        logic [7:0] motor_command_port;
        logic [3:0] phase_enables;
        logic pulse;
        logic sign;
    } mcc_drive_t;

endpackage

// File: src/mcc_core.sv
// Motion control core: encoder count, sample timer, four control modes,
// compensation filter, PWM and byte motor outputs, commutator, status.
// Assumes Avalon-MM master on i_ref_clk; pins arrive asynchronously.
//
// Overview of operation
// RULE_01 - Encoder channels decoded to quadrature counts in a 24-bit up/down position.
// RULE_02 - Exactly one of four selected control algorithms runs.
// RULE_03 - Host exchanges commands and data over the shared register bus.
// RULE_04 - Error between desired and actual passes through a programmable filter.
// RULE_05 - Motor command appears as a byte and as a PWM signal.
// RULE_06 - Profile generator moves setpoints in trapezoid and integral velocity modes.
// RULE_07 - Encoder position steps phase enables through a programmable pattern.
// RULE_08 - Programmable phase overlap and phase advance shape the phase enables.
// RULE_09 - Internal flags kept; profile-running and idle flags driven on pins.
// RULE_10 - Active-low limit and stop inputs interrupt normal control.
// RULE_11 - Host access any time; motor command computed once per sample.
// RULE_12 - Sample period set by host-programmed sample timer count.
// RULE_13 - Active-low sync input aligns sample timers of several controllers.
// RULE_14 - In idle, low sync clears and holds timer; high restarts from reload.
// RULE_15 - Limit sets flag, forces idle before next sample, command zero.
// RULE_16 - Stop during integral velocity mode sets flag and decelerates to rest.
// RULE_17 - PWM period 100 clocks, duty from magnitude, separate sign output.
// RULE_18 - Reset enters idle with zero command until host selects a mode.
`timescale 1ns/1ps

module mcc_core #(
    parameter int unsigned POS_W = 24 // Position counter width
) (
    input wire logic i_ref_clk, // Core clock
    input wire logic i_rst_n, // Asynchronous reset, active low
    input wire logic [7:0] i_avs_address, // Byte address
    input wire logic i_avs_read, // Read request
    input wire logic i_avs_write, // Write request
    input wire logic [31:0] i_avs_writedata, // Write data
    output logic [31:0] o_avs_readdata, // Read data
    output logic o_avs_waitrequest, // Stall
    input wire logic [1:0] i_encoder_channels, // Bit 0 channel A, bit 1 channel B
    input wire logic i_limit_n, // Emergency limit, active low
    input wire logic i_stop_n, // Emergency stop, active low
    input wire logic i_sync_n, // Sample timer sync, active low
    output mcc_pkg::mcc_drive_t o_drive, // Motor and phase outputs
    output logic o_prof, // Profiled move executing
    output logic o_init, // Idle mode
    output logic o_irq // Interrupt, active high
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [4:0] p1;
        logic [4:0] p2;
        logic [1:0] eprv;
        logic run;
        mcc_pkg::mcc_mode_t mode;
        logic [mcc_pkg::ST_W-1:0] st;
        logic [mcc_pkg::ST_W-1:0] mask;
        logic [15:0] samp;
        logic [15:0] filt;
        logic [23:0] cmd;
        logic [23:0] prof;
        logic [23:0] comm;
        logic [15:0] pat;
        logic [POS_W-1:0] pos;
        logic [POS_W-1:0] pos_last;
        logic [15:0] tmr;
        logic hold;
        logic [POS_W-1:0] sp;
        logic [15:0] pv;
        logic [15:0] spd;
        logic [POS_W-1:0] eprev;
        logic [7:0] mcmd;
        logic [6:0] pwm;
        logic [7:0] duty;
        logic [7:0] ph_cnt;
        logic [1:0] ph_idx;
        logic proff;
        logic ack;
        logic [31:0] rdata;
        mcc_pkg::mcc_drive_t drv;
    } mcc_state_t;

    localparam mcc_state_t RST_S = '{
        p1: 5'h1F, p2: 5'h1F, mode: mcc_pkg::MD_POS,
        samp: mcc_pkg::RST_SAMP, filt: mcc_pkg::RST_FILT,
        prof: mcc_pkg::RST_PROF, comm: mcc_pkg::RST_COMM,
        pat: mcc_pkg::RST_PAT, drv: '{motor_command_port: 8'h80, default: '0},
        default: '0};

    mcc_state_t s_q;
    mcc_state_t s_d;
    logic rst_m_q;
    logic rst_s_q;

    function automatic logic [3:0] pat_nib(input logic [15:0] p, input logic [1:0] i);
        return p[{i, 2'b00} +: 4];
    endfunction

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic a;
        logic b;
        logic chg;
        logic lim;
        logic stp;
        logic syn;
        logic tick;
        logic [7:0] cps;
        logic [8:0] eff;
        logic [1:0] ei;
        logic [POS_W-1:0] vel;
        logic [POS_W-1:0] err;
        logic signed [35:0] u;
        logic [POS_W-1:0] rem;
        logic [POS_W-1:0] ar;
        logic [31:0] ss;
        logic [33:0] dd;
        logic [16:0] sa;
        logic [15:0] ns;
        logic [POS_W-1:0] stepm;
        logic [15:0] vt;
        logic [15:0] ac;
        logic [7:0] mag;
        logic [mcc_pkg::ST_W-1:0] set;
        logic [mcc_pkg::ST_W-1:0] clr;
        a = 1'b0;
        b = 1'b0;
        chg = 1'b0;
        lim = 1'b0;
        stp = 1'b0;
        syn = 1'b0;
        tick = 1'b0;
        cps = 8'h00;
        eff = 9'h000;
        ei = 2'b00;
        vel = '0;
        err = '0;
        u = '0;
        rem = '0;
        ar = '0;
        ss = 32'h0;
        dd = 34'h0;
        sa = 17'h0;
        ns = 16'h0;
        stepm = '0;
        vt = 16'h0;
        ac = 16'h0;
        mag = 8'h00;
        set = '0;
        clr = '0;
        s_d = s_q;

        // Pin synchronisers: encoder B, A, limit, stop, sync
        s_d.p1 = {i_encoder_channels, i_limit_n, i_stop_n, i_sync_n};
        s_d.p2 = s_q.p1;
        a = s_q.p2[3];
        b = s_q.p2[4];
        lim = ~s_q.p2[2]; // RULE_10
        stp = ~s_q.p2[1];
        syn = ~s_q.p2[0];

        // Quadrature decode, four counts per encoder cycle
        s_d.eprv = {b, a};
        chg = (a ^ s_q.eprv[0]) ^ (b ^ s_q.eprv[1]); // RULE_01
        cps = (s_q.comm[7:0] == 8'h00) ? 8'h01 : s_q.comm[7:0];
        if (chg) begin
            if (a ^ s_q.eprv[1]) begin
                s_d.pos = s_q.pos + POS_W'(1); // RULE_01
                if (s_q.ph_cnt >= cps - 8'h01) begin
                    s_d.ph_cnt = 8'h00; // RULE_07
                    s_d.ph_idx = s_q.ph_idx + 2'b01;
                end else begin
                    s_d.ph_cnt = s_q.ph_cnt + 8'h01;
                end
            end else begin
                s_d.pos = s_q.pos - POS_W'(1); // RULE_01
                if (s_q.ph_cnt == 8'h00) begin
                    s_d.ph_cnt = cps - 8'h01; // RULE_07
                    s_d.ph_idx = s_q.ph_idx - 2'b01;
                end else begin
                    s_d.ph_cnt = s_q.ph_cnt - 8'h01;
                end
            end
        end

        // Commutator with advance and overlap
        eff = {1'b0, s_q.ph_cnt} + {1'b0, s_q.comm[15:8]}; // RULE_08
        ei = s_q.ph_idx;
        if (eff >= {1'b0, cps}) begin
            eff = eff - {1'b0, cps}; // RULE_08
            ei = ei + 2'b01;
        end
        s_d.drv.phase_enables = pat_nib(s_q.pat, ei); // RULE_07
        if (eff + {1'b0, s_q.comm[23:16]} >= {1'b0, cps}) begin
            s_d.drv.phase_enables = pat_nib(s_q.pat, ei) | pat_nib(s_q.pat, ei + 2'b01); // RULE_08
        end

        // Sample timer with sync hold in idle
        if (!s_q.run && syn) begin
            s_d.tmr = 16'h0000; // RULE_14
            s_d.hold = 1'b1;
        end else if (s_q.hold) begin
            s_d.tmr = s_q.samp; // RULE_14
            s_d.hold = 1'b0;
        end else if (s_q.tmr == 16'h0000) begin
            tick = 1'b1; // RULE_12
            s_d.tmr = s_q.samp;
        end else begin
            s_d.tmr = s_q.tmr - 16'h0001; // RULE_13
        end

        // Emergency inputs
        if (stp) begin
            set[mcc_pkg::ST_STOP] = 1'b1; // RULE_16
        end
        if (tick) begin
            set[mcc_pkg::ST_TICK] = 1'b1;
        end

        // Control loop, once per sample
        ac = {8'h00, s_q.prof[7:0]};
        if (!s_q.run) begin
            s_d.mcmd = 8'h00; // RULE_18
            s_d.eprev = '0;
            s_d.sp = s_q.pos;
            s_d.pv = 16'h0000;
            s_d.spd = 16'h0000;
            s_d.proff = 1'b0;
        end else if (tick) begin // RULE_11
            vel = s_q.pos - s_q.pos_last;
            s_d.pos_last = s_q.pos;
            unique case (s_q.mode) // RULE_02
                mcc_pkg::MD_POS: begin
                    err = s_q.cmd - s_q.pos; // RULE_04
                end
                mcc_pkg::MD_PVEL: begin
                    err = POS_W'($signed(s_q.cmd[15:0])) - POS_W'($signed(vel[15:0]));
                end
                mcc_pkg::MD_TRAP: begin
                    err = s_q.sp - s_q.pos;
                    rem = s_q.cmd - s_q.sp; // RULE_06
                    ar = rem[POS_W-1] ? -rem : rem;
                    ss = s_q.spd * s_q.spd;
                    dd = {ac[8:0], 1'b0} * ar;
                    sa = {1'b0, s_q.spd} + {1'b0, ac};
                    if (ar == '0) begin
                        s_d.spd = 16'h0000;
                        s_d.proff = 1'b0;
                        set[mcc_pkg::ST_DONE] = s_q.proff;
                    end else begin
                        s_d.proff = 1'b1; // RULE_09
                        if ({2'b00, ss} >= dd) begin
                            ns = (s_q.spd > ac) ? s_q.spd - ac : 16'h0001;
                        end else begin
                            ns = (sa > {1'b0, s_q.prof[23:8]}) ? s_q.prof[23:8] : sa[15:0];
                        end
                        s_d.spd = ns;
                        stepm = (POS_W'(ns) > ar) ? ar : POS_W'(ns);
                        s_d.sp = rem[POS_W-1] ? s_q.sp - stepm : s_q.sp + stepm; // RULE_06
                    end
                end
                mcc_pkg::MD_IVEL: begin
                    err = s_q.sp - s_q.pos;
                    vt = s_q.st[mcc_pkg::ST_STOP] ? 16'h0000 : s_q.cmd[15:0]; // RULE_16
                    if ($signed(s_q.pv) < $signed(vt)) begin
                        s_d.pv = ($signed(vt - s_q.pv) > $signed(ac)) ? s_q.pv + ac : vt;
                    end else begin
                        s_d.pv = ($signed(s_q.pv - vt) > $signed(ac)) ? s_q.pv - ac : vt;
                    end
                    s_d.sp = s_q.sp + POS_W'($signed(s_d.pv)); // RULE_06
                end
            endcase
            u = (36'(signed'({1'b0, s_q.filt[7:0]})) * 36'(signed'(err))
                - 36'(signed'({1'b0, s_q.filt[15:8]})) * 36'(signed'(s_q.eprev)))
                >>> mcc_pkg::FILT_SHIFT; // RULE_04
            s_d.eprev = err;
            if (u > 36'sd127) begin
                s_d.mcmd = 8'h7F;
            end else if (u < -36'sd127) begin
                s_d.mcmd = 8'h81;
            end else begin
                s_d.mcmd = u[7:0];
            end
        end

        // Limit forces idle before the next sample
        if (lim) begin
            set[mcc_pkg::ST_LIMIT] = 1'b1; // RULE_15
            s_d.run = 1'b0;
            s_d.mcmd = 8'h00;
        end

        // Motor command outputs
        s_d.pwm = (s_q.pwm >= mcc_pkg::PWM_CNT - 7'h01) ? 7'h00 : s_q.pwm + 7'h01; // RULE_17
        mag = s_q.mcmd[7] ? -s_q.mcmd : s_q.mcmd;
        // Duty loads only at period start so the pulse never rises mid-period
        if (s_q.pwm >= mcc_pkg::PWM_CNT - 7'h01) begin
            s_d.duty = mag; // RULE_17
        end
        s_d.drv.pulse = ({1'b0, s_q.pwm} < s_q.duty); // RULE_17
        s_d.drv.sign = s_q.mcmd[7]; // RULE_17
        s_d.drv.motor_command_port = s_q.mcmd ^ 8'h80; // RULE_05

        // Register bus: first edge latches read data, second completes
        s_d.ack = 1'b0;
        if ((i_avs_read || i_avs_write) && !s_q.ack) begin
            s_d.ack = 1'b1;
            unique case (i_avs_address) // RULE_03
                mcc_pkg::OFS_CTRL: s_d.rdata = {29'h0, s_q.mode, s_q.run};
                mcc_pkg::OFS_STAT: s_d.rdata = {28'h0, s_q.st};
                mcc_pkg::OFS_MASK: s_d.rdata = {28'h0, s_q.mask};
                mcc_pkg::OFS_SAMP: s_d.rdata = {16'h0, s_q.samp};
                mcc_pkg::OFS_FILT: s_d.rdata = {16'h0, s_q.filt};
                mcc_pkg::OFS_CMD: s_d.rdata = {8'h0, s_q.cmd};
                mcc_pkg::OFS_PROF: s_d.rdata = {8'h0, s_q.prof};
                mcc_pkg::OFS_POS: s_d.rdata = {8'h0, s_q.pos};
                mcc_pkg::OFS_COMM: s_d.rdata = {8'h0, s_q.comm};
                mcc_pkg::OFS_PAT: s_d.rdata = {16'h0, s_q.pat};
                mcc_pkg::OFS_MOTOR: s_d.rdata = {18'h0, s_q.drv.phase_enables,
                    s_q.proff, ~s_q.run, s_q.mcmd};
                default: s_d.rdata = 32'h0;
            endcase
        end else if (s_q.ack && i_avs_write) begin
            unique case (i_avs_address)
                mcc_pkg::OFS_CTRL: begin
                    s_d.run = i_avs_writedata[0] & ~lim; // RULE_18
                    s_d.mcmd = i_avs_writedata[0] ? s_d.mcmd : 8'h00; // RULE_18
                    s_d.mode = mcc_pkg::mcc_mode_t'(i_avs_writedata[2:1]); // RULE_02
                end
                mcc_pkg::OFS_STAT: clr = i_avs_writedata[mcc_pkg::ST_W-1:0];
                mcc_pkg::OFS_MASK: s_d.mask = i_avs_writedata[mcc_pkg::ST_W-1:0];
                mcc_pkg::OFS_SAMP: s_d.samp = i_avs_writedata[15:0]; // RULE_12
                mcc_pkg::OFS_FILT: s_d.filt = i_avs_writedata[15:0]; // RULE_04
                mcc_pkg::OFS_CMD: s_d.cmd = i_avs_writedata[23:0];
                mcc_pkg::OFS_PROF: s_d.prof = i_avs_writedata[23:0];
                mcc_pkg::OFS_POS: s_d.pos = i_avs_writedata[POS_W-1:0];
                mcc_pkg::OFS_COMM: s_d.comm = i_avs_writedata[23:0]; // RULE_08
                mcc_pkg::OFS_PAT: s_d.pat = i_avs_writedata[15:0]; // RULE_07
                default: ;
            endcase
        end
        s_d.st = (s_q.st & ~clr) | set; // RULE_09
    end

    always_ff @(posedge i_ref_clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            s_q <= RST_S; // RULE_18
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_avs_readdata = s_q.rdata;
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~s_q.ack;
    assign o_drive = s_q.drv;
    assign o_prof = s_q.proff; // RULE_09
    assign o_init = ~s_q.run; // RULE_09
    assign o_irq = |(s_q.st & s_q.mask);

endmodule // mcc_core

// File: verif/mcc_enc_model.sv
// Quadrature encoder model driving the core's encoder channels.
// Assumes the caller holds each state at least three clocks.
`timescale 1ns/1ps
module mcc_enc_model (
    input wire logic i_clk, // Clock
    input wire logic i_step, // Advance one count
    input wire logic i_up, // 1 = channel A leads
    output logic [1:0] o_channels // Bit 0 A, bit 1 B
);
    logic [1:0] ph_q = 2'h0;
    always_ff @(posedge i_clk) begin
        if (i_step) begin
            ph_q <= i_up ? ph_q + 2'h1 : ph_q - 2'h1;
        end
    end
    // Gray order 00,01,11,10 puts A ahead when counting up
    assign o_channels = {ph_q[1], ph_q[1] ^ ph_q[0]};
endmodule // mcc_enc_model

// File: verif/mcc_core_checker.sv
// Port-level assertions for the motion control core.
// Assumes a single clock domain; bound into mcc_core.
`timescale 1ns/1ps
module mcc_core_checker (
    input wire logic i_ref_clk, // Clock
    input wire logic i_rst_n, // Reset, active low
    input wire logic [7:0] i_avs_address, // Address
    input wire logic i_avs_read, // Read
    input wire logic i_avs_write, // Write
    input wire logic [31:0] i_avs_writedata, // Write data
    input wire logic [31:0] o_avs_readdata, // Read data
    input wire logic o_avs_waitrequest, // Stall
    input wire logic [1:0] i_encoder_channels, // Encoder
    input wire logic i_limit_n, // Limit
    input wire logic i_stop_n, // Stop
    input wire logic i_sync_n, // Sync
    input wire mcc_pkg::mcc_drive_t o_drive, // Drive
    input wire logic o_prof, // Profile
    input wire logic o_init, // Idle
    input wire logic o_irq // Interrupt
);
    logic req;
    logic seen_q;
    logic [7:0] idle_q;
    logic [9:0] gap_q;
    assign req = i_avs_read | i_avs_write;
    // Idle run length and spacing of PWM rising edges
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idle_q <= 8'h00;
            gap_q <= 10'h000;
            seen_q <= 1'b0;
        end else begin
            idle_q <= !o_init ? 8'h00 : (idle_q == 8'hFF ? idle_q : idle_q + 8'h01);
            gap_q <= $rose(o_drive.pulse) ? 10'h000 : (gap_q == 10'h3FF ? gap_q : gap_q + 10'h001);
            seen_q <= seen_q | $rose(o_drive.pulse);
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_limit_held;
        $fell(i_limit_n) ##1 !i_limit_n [*6];
    endsequence
    a_wait_first: assert property ($rose(req) |-> o_avs_waitrequest)
        else $error("waitrequest low in first request cycle");
    a_wait_end: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("request not answered in two cycles");
    a_wait_idle: assert property (!req |-> !o_avs_waitrequest)
        else $error("waitrequest without request");
    a_idle_cmd: assert property (o_init && $past(o_init) |-> o_drive.motor_command_port == 8'h80)
        else $error("motor command not zero while idle");
    a_limit_forces_idle: assert property (s_limit_held |-> o_init && o_drive.motor_command_port == 8'h80)
        else $error("limit did not force idle and zero command");
    a_limit_soon: assert property ($fell(i_limit_n) |-> ##[1:5] o_init)
        else $error("idle not reached soon after limit");
    a_idle_quiet: assert property (idle_q > 8'h78 |-> !o_drive.pulse && !o_drive.sign)
        else $error("pwm active while idle");
    a_pwm_period: assert property ($rose(o_drive.pulse) && seen_q && gap_q != 10'h3FF |-> (gap_q % 10'h064) == 10'h063)
        else $error("pwm period not 100 clocks");
    a_idle_noprof: assert property (o_init && $past(o_init) |-> !o_prof)
        else $error("profile flag while idle");
endmodule // mcc_core_checker
bind mcc_core mcc_core_checker u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_encoder_channels(i_encoder_channels),
    .i_limit_n(i_limit_n), .i_stop_n(i_stop_n), .i_sync_n(i_sync_n), .o_drive(o_drive),
    .o_prof(o_prof), .o_init(o_init), .o_irq(o_irq));

// File: verif/test_motion_control_core.sv
// Self-checking bench for the motion control core.
// Assumes the core, its package, checker and encoder model are compiled.
`timescale 1ns/1ps
module test_motion_control_core;
    logic clk, rst_n, rd, wr, limit_n, stop_n, sync_n, step, up, wait_rq, prof, init, irq;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, got;
    logic [1:0] enc;
    mcc_pkg::mcc_drive_t drive;
    int miscompares, tests_run, hi;
    mcc_core dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_rq), .i_encoder_channels(enc), .i_limit_n(limit_n),
        .i_stop_n(stop_n), .i_sync_n(sync_n), .o_drive(drive), .o_prof(prof),
        .o_init(init), .o_irq(irq));
    mcc_enc_model u_enc (.i_clk(clk), .i_step(step), .i_up(up), .o_channels(enc));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
        end while (wait_rq !== 1'b0);
        got = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(got & m, e);
    endtask
    task automatic steps(input logic u, input int n);
        repeat (n) begin
            @(posedge clk);
            step <= 1'b1;
            up <= u;
            @(posedge clk);
            step <= 1'b0;
            cyc(4);
        end
    endtask
    task automatic pwm(input logic [7:0] port, input logic s);
        hi = 0;
        repeat (200) begin
            @(negedge clk);
            hi += int'(drive.pulse);
        end
        chk({24'h000000, drive.motor_command_port}, {24'h000000, port});
        chk({31'h0, drive.sign}, {31'h0, s});
        chk(32'(hi), 32'h0000000A);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #800000;
        miscompares++;
        complete_run();
    end
    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_n, rd, wr, step, up} = 5'b00001;
        {limit_n, stop_n, sync_n} = 3'b111;
        addr = 8'h00;
        wdata = 32'h00000000;
        miscompares = 0;
        tests_run = 0;
        cyc(5);
        rst_n <= 1'b1;
        cyc(3);
        rdchk(mcc_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h0);
        rdchk(mcc_pkg::OFS_SAMP, 32'hFFFFFFFF, {16'h0, mcc_pkg::RST_SAMP});
        rdchk(mcc_pkg::OFS_FILT, 32'hFFFFFFFF, {16'h0, mcc_pkg::RST_FILT});
        rdchk(mcc_pkg::OFS_PROF, 32'hFFFFFFFF, {8'h0, mcc_pkg::RST_PROF});
        rdchk(mcc_pkg::OFS_COMM, 32'hFFFFFFFF, {8'h0, mcc_pkg::RST_COMM});
        rdchk(mcc_pkg::OFS_PAT, 32'hFFFFFFFF, {16'h0, mcc_pkg::RST_PAT});
        rdchk(mcc_pkg::OFS_MOTOR, 32'h000003FF, 32'h00000100);
        bus(1'b1, 8'h3C, 32'hFFFFFFFF);
        rdchk(8'h3C, 32'hFFFFFFFF, 32'h0);
        chk({31'h0, init}, 32'h1);
        $display("reset test done");
        bus(1'b1, mcc_pkg::OFS_POS, 32'h00FFFFFE);
        steps(1'b1, 4);
        rdchk(mcc_pkg::OFS_POS, 32'h00FFFFFF, 32'h00000002);
        steps(1'b0, 5);
        rdchk(mcc_pkg::OFS_POS, 32'h00FFFFFF, 32'h00FFFFFD);
        rdchk(mcc_pkg::OFS_MOTOR, 32'h00003C00, 32'h00002000);
        chk({28'h0, drive.phase_enables}, 32'h8);
        bus(1'b1, mcc_pkg::OFS_COMM, 32'h00010010);
        cyc(2);
        chk({28'h0, drive.phase_enables}, 32'h9);
        $display("encoder test done");
        bus(1'b1, mcc_pkg::OFS_SAMP, 32'h00000013);
        @(posedge clk);
        sync_n <= 1'b0;
        cyc(30);
        bus(1'b1, mcc_pkg::OFS_STAT, 32'h0000000F);
        cyc(30);
        rdchk(mcc_pkg::OFS_STAT, 32'h4, 32'h0);
        @(posedge clk);
        sync_n <= 1'b1;
        cyc(6);
        rdchk(mcc_pkg::OFS_STAT, 32'h4, 32'h0);
        cyc(20);
        rdchk(mcc_pkg::OFS_STAT, 32'h4, 32'h4);
        $display("sample timer test done");
        bus(1'b1, mcc_pkg::OFS_POS, 32'h00000100);
        bus(1'b1, mcc_pkg::OFS_CMD, 32'h00000105);
        bus(1'b1, mcc_pkg::OFS_CTRL, 32'h00000001);
        cyc(80);
        pwm(8'h85, 1'b0);
        bus(1'b1, mcc_pkg::OFS_CMD, 32'h000000FB);
        cyc(80);
        pwm(8'h7B, 1'b1);
        rdchk(mcc_pkg::OFS_MOTOR, 32'h000000FF, 32'h000000FB);
        @(posedge clk);
        limit_n <= 1'b0;
        cyc(6);
        chk({31'h0, init}, 32'h1);
        chk({24'h0, drive.motor_command_port}, 32'h80);
        bus(1'b1, mcc_pkg::OFS_CTRL, 32'h00000001);
        rdchk(mcc_pkg::OFS_CTRL, 32'h1, 32'h0);
        @(posedge clk);
        limit_n <= 1'b1;
        cyc(4);
        rdchk(mcc_pkg::OFS_STAT, 32'h1, 32'h1);
        bus(1'b1, mcc_pkg::OFS_MASK, 32'h00000001);
        cyc(1);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, mcc_pkg::OFS_MASK, 32'h00000000);
        cyc(1);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, mcc_pkg::OFS_MASK, 32'h00000001);
        bus(1'b1, mcc_pkg::OFS_STAT, 32'h00000001);
        rdchk(mcc_pkg::OFS_STAT, 32'h1, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("position and limit test done");
        bus(1'b1, mcc_pkg::OFS_CMD, 32'h00000000);
        bus(1'b1, mcc_pkg::OFS_CTRL, {29'h0, mcc_pkg::MD_PVEL, 1'b1});
        cyc(250);
        chk({23'h0, init, drive.motor_command_port}, 32'h80);
        bus(1'b1, mcc_pkg::OFS_CTRL, 32'h00000000);
        cyc(3);
        chk({31'h0, init}, 32'h1);
        bus(1'b1, mcc_pkg::OFS_CMD, 32'h00000140);
        bus(1'b1, mcc_pkg::OFS_CTRL, {29'h0, mcc_pkg::MD_TRAP, 1'b1});
        cyc(50);
        chk({30'h0, prof, init}, 32'h2);
        bus(1'b1, mcc_pkg::OFS_CTRL, 32'h00000000);
        bus(1'b1, mcc_pkg::OFS_CMD, 32'h00000010);
        bus(1'b1, mcc_pkg::OFS_CTRL, {29'h0, mcc_pkg::MD_IVEL, 1'b1});
        cyc(50);
        @(posedge clk);
        stop_n <= 1'b0;
        cyc(6);
        rdchk(mcc_pkg::OFS_STAT, 32'h2, 32'h2);
        @(posedge clk);
        stop_n <= 1'b1;
        bus(1'b1, mcc_pkg::OFS_CTRL, 32'h00000000);
        $display("mode test done");
        complete_run();
    end
endmodule // test_motion_control_core
